/* common/cprx_defines.svh */
// offsets, field positions, reset values and timing counts
`ifndef CPRX_DEFINES_SVH
`define CPRX_DEFINES_SVH

`define CPRX_IDX_RXKV0 10'h080
`define CPRX_IDX_RXKV1 10'h081
`define CPRX_IDX_RXKV2 10'h082
`define CPRX_IDX_RXKV3 10'h083
`define CPRX_IDX_RXKV4 10'h084
`define CPRX_IDX_TXKV0 10'h090
`define CPRX_IDX_TXKV1 10'h091
`define CPRX_IDX_TXKV2 10'h092
`define CPRX_IDX_TXKV3 10'h093
`define CPRX_IDX_TXKV4 10'h094
`define CPRX_IDX_MIRROR 10'h0C0
`define CPRX_IDX_CTRL 10'h0C1

`define CPRX_KEY_RESET 40'h00_0000_0000
`define CPRX_MIRROR_RESET 8'h00
`define CPRX_CTRL_RESET 8'h00
`define CPRX_MIRROR_MASK 8'h4F
`define CPRX_CTRL_MASK 8'h03

`define CPRX_BIT_TO_DIS 6
`define CPRX_BIT_CHKSUM 3
`define CPRX_BIT_FAST_LINK_VERIFY 2
`define CPRX_BIT_SPEEDUP 1
`define CPRX_BIT_I2C_FAST 0
`define CPRX_BIT_NO_DECRYPT 1
`define CPRX_BIT_EN_MODE 0

`define CPRX_HTRANS_NONSEQ 2'h2

`define CPRX_SHORT_FAST 8'h02
`define CPRX_SHORT_SLOW 8'h10
`define CPRX_LONG_FAST 8'h10
`define CPRX_LONG_SLOW 8'h80

`define CPRX_CLK_HZ 20000000
`define CPRX_CLK_NS 50
`define CPRX_BUS_TIMEOUT_MS 1000
`define CPRX_BUS_TIMEOUT_CYC \
	(`CPRX_BUS_TIMEOUT_MS * (`CPRX_CLK_HZ / 1000))
`define CPRX_STD_HALF_NS 5000
`define CPRX_FAST_HALF_NS 1250
`define CPRX_STD_HALF_CYC \
	((`CPRX_STD_HALF_NS + `CPRX_CLK_NS - 1) / `CPRX_CLK_NS)
`define CPRX_FAST_HALF_CYC \
	((`CPRX_FAST_HALF_NS + `CPRX_CLK_NS - 1) / `CPRX_CLK_NS)

`endif

/* common/cprx_pkg.sv */
// types shared by the protection receiver register bank
package cprx_pkg;
	typedef logic [7:0] cprx_byte_t;
	typedef logic [23:0] cprx_pixel_t;
	typedef enum {
		CPRX_SEL_NONE, CPRX_SEL_RXKV, CPRX_SEL_TXKV,
		CPRX_SEL_MIRROR, CPRX_SEL_CTRL
	} cprx_sel_t;
endpackage : cprx_pkg

/* design/cprx_debug_regs.sv */
// protection receiver key vectors, debug mirror and debug control
// What this block does
// - receiver key bytes 0-2 read-only, reset zero
// - receiver key bytes 3-4 read-only, reset zero
// - transmitter key bytes 0-4 read-only, reset zero
// - mirror fields follow remote, ignore local writes
// - bus free after one idle second
// - ones-complement channel checksum after each line
// - speed-up flag shortens authentication timers
// - fast flag selects fast bus timing
// - bypass sends encrypted pixels to outputs
// - enable mode skips re-enabling enabled transmitters
`timescale 1ns/1ns
`include "cprx_defines.svh"
module cprx_debug_regs #(
	parameter int BUS_TIMEOUT_CYCLES = `CPRX_BUS_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [39:0] rx_key_vector,
	input wire logic rx_key_load,
	input wire logic [39:0] tx_key_vector,
	input wire logic tx_key_load,
	input wire cprx_pkg::cprx_byte_t remote_debug_value,
	input wire logic remote_debug_load,
	input wire logic bus_activity,
	output logic bus_free,
	output logic bus_timeout_disable,
	output logic protect_master_fast_timing,
	output cprx_pkg::cprx_byte_t scl_half_cycles,
	output logic auth_timer_speedup,
	input wire logic frame_start,
	output logic fast_link_verify,
	output logic short_check_strobe,
	output logic long_check_strobe,
	input wire logic pix_valid,
	input wire cprx_pkg::cprx_pixel_t pix_in,
	input wire logic line_end,
	output logic line_checksum_enable,
	output cprx_pkg::cprx_pixel_t line_checksum,
	output logic line_checksum_valid,
	input wire cprx_pkg::cprx_pixel_t decrypted_pixel,
	input wire cprx_pkg::cprx_pixel_t encrypted_pixel,
	input wire logic video_valid_in,
	output cprx_pkg::cprx_pixel_t video_out,
	output logic video_valid_out,
	input wire logic auth_start,
	input wire logic downstream_enabled,
	output logic downstream_enable_req
);
	import cprx_pkg::*;

	function automatic cprx_sel_t decode(input logic [9:0] idx);
		cprx_sel_t s;
		s = CPRX_SEL_NONE;
		if (idx >= `CPRX_IDX_RXKV0 && idx <= `CPRX_IDX_RXKV4) begin
			s = CPRX_SEL_RXKV;
		end else if (idx >= `CPRX_IDX_TXKV0 && idx <= `CPRX_IDX_TXKV4) begin
			s = CPRX_SEL_TXKV;
		end else if (idx == `CPRX_IDX_MIRROR) begin
			s = CPRX_SEL_MIRROR;
		end else if (idx == `CPRX_IDX_CTRL) begin
			s = CPRX_SEL_CTRL;
		end
		return s;
	endfunction : decode

	function automatic cprx_byte_t key_byte(input logic [39:0] kv,
		input logic [2:0] n);
		cprx_byte_t b;
		b = 8'h00;
		unique case (n)
			3'h0: b = kv[7:0];
			3'h1: b = kv[15:8];
			3'h2: b = kv[23:16];
			3'h3: b = kv[31:24];
			3'h4: b = kv[39:32];
			default: b = 8'h00;
		endcase
		return b;
	endfunction : key_byte

	// end-around carry keeps the sum in ones-complement form
	function automatic cprx_byte_t ones_add(input cprx_byte_t a,
		input cprx_byte_t b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction : ones_add

	logic [39:0] rx_key_reg;
	logic [39:0] tx_key_reg;
	cprx_byte_t mirror_reg;
	cprx_byte_t ctrl_reg;
	logic wr_pend_reg;
	logic [9:0] wr_idx_reg;
	logic [31:0] hrdata_reg;
	logic [9:0] addr_idx;
	logic addr_phase;
	logic ctrl_wr;
	cprx_byte_t ctrl_view;
	cprx_byte_t rd_byte;
	logic [25:0] idle_reg;
	logic bus_free_reg;
	logic fast_link_verify_d_reg;
	logic lv_restart;
	cprx_byte_t short_period;
	cprx_byte_t long_period;
	cprx_pixel_t chk_acc_reg;
	cprx_pixel_t line_checksum_reg;
	logic line_checksum_valid_reg;
	cprx_pixel_t video_out_reg;
	logic video_valid_reg;
	logic reenable_reg;

	// single-cycle slave: never stalls, never errors
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign addr_idx = haddr[11:2];
	assign addr_phase = hsel && hready && htrans == `CPRX_HTRANS_NONSEQ;
	assign ctrl_wr = wr_pend_reg && wr_idx_reg == `CPRX_IDX_CTRL;
	// forward a write still in its data phase to a read right behind it
	assign ctrl_view = ctrl_wr ? (hwdata[7:0] & `CPRX_CTRL_MASK) : ctrl_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 10'h000;
		end else if (hready) begin
			wr_pend_reg <= addr_phase && hwrite;
			wr_idx_reg <= addr_idx;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		unique case (decode(addr_idx))
			CPRX_SEL_RXKV: rd_byte = key_byte(rx_key_reg,
				3'(addr_idx - `CPRX_IDX_RXKV0));
			CPRX_SEL_TXKV: rd_byte = key_byte(tx_key_reg,
				3'(addr_idx - `CPRX_IDX_TXKV0));
			CPRX_SEL_MIRROR: rd_byte = mirror_reg;
			CPRX_SEL_CTRL: rd_byte = ctrl_view;
			CPRX_SEL_NONE: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata_reg <= {24'h00_0000, rd_byte};
		end
	end

	// key vectors are loaded only by key storage and the link
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_key_reg <= `CPRX_KEY_RESET;
		end else if (rx_key_load) begin
			rx_key_reg <= rx_key_vector;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_key_reg <= `CPRX_KEY_RESET;
		end else if (tx_key_load) begin
			tx_key_reg <= tx_key_vector;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mirror_reg <= `CPRX_MIRROR_RESET;
		end else if (remote_debug_load) begin
			mirror_reg <= remote_debug_value & `CPRX_MIRROR_MASK;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= `CPRX_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= hwdata[7:0] & `CPRX_CTRL_MASK;
		end
	end

	assign bus_timeout_disable = mirror_reg[`CPRX_BIT_TO_DIS];
	assign line_checksum_enable = mirror_reg[`CPRX_BIT_CHKSUM];
	assign fast_link_verify = mirror_reg[`CPRX_BIT_FAST_LINK_VERIFY];
	assign auth_timer_speedup = mirror_reg[`CPRX_BIT_SPEEDUP];
	assign protect_master_fast_timing = mirror_reg[`CPRX_BIT_I2C_FAST];
	assign scl_half_cycles = protect_master_fast_timing ?
		8'(`CPRX_FAST_HALF_CYC) : 8'(`CPRX_STD_HALF_CYC);

	// idle counter saturates one past the limit; free means "at least" the limit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idle_reg <= 26'h000_0000;
		end else if (bus_activity) begin
			idle_reg <= 26'h000_0000;
		end else if (idle_reg <= 26'(BUS_TIMEOUT_CYCLES)) begin
			idle_reg <= idle_reg + 26'h000_0001;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_free_reg <= 1'b0;
		end else begin
			bus_free_reg <= !bus_timeout_disable && !bus_activity &&
				idle_reg >= 26'(BUS_TIMEOUT_CYCLES);
		end
	end
	assign bus_free = bus_free_reg;

	assign short_period = fast_link_verify ? `CPRX_SHORT_FAST : `CPRX_SHORT_SLOW;
	assign long_period = fast_link_verify ? `CPRX_LONG_FAST : `CPRX_LONG_SLOW;
	// a rate change restarts both counts to avoid a stretched interval
	assign lv_restart = fast_link_verify_d_reg != fast_link_verify;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fast_link_verify_d_reg <= 1'b0;
		end else begin
			fast_link_verify_d_reg <= fast_link_verify;
		end
	end

	cprx_interval short_cnt (
		.clk(clk),
		.nrst(nrst),
		.tick(frame_start),
		.restart(lv_restart),
		.period(short_period),
		.hit(short_check_strobe)
	);

	cprx_interval long_cnt (
		.clk(clk),
		.nrst(nrst),
		.tick(frame_start),
		.restart(lv_restart),
		.period(long_period),
		.hit(long_check_strobe)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chk_acc_reg <= 24'h00_0000;
		end else if (line_end) begin
			chk_acc_reg <= 24'h00_0000;
		end else if (pix_valid) begin
			for (int c = 0; c < 3; c++) begin
				chk_acc_reg[c*8 +: 8] <= ones_add(chk_acc_reg[c*8 +: 8],
					pix_in[c*8 +: 8]);
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			line_checksum_reg <= 24'h00_0000;
			line_checksum_valid_reg <= 1'b0;
		end else begin
			line_checksum_valid_reg <= line_end && line_checksum_enable;
			if (line_end && line_checksum_enable) begin
				line_checksum_reg <= ~chk_acc_reg;
			end
		end
	end
	assign line_checksum = line_checksum_reg;
	assign line_checksum_valid = line_checksum_valid_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			video_out_reg <= 24'h00_0000;
			video_valid_reg <= 1'b0;
		end else begin
			video_valid_reg <= video_valid_in;
			video_out_reg <= ctrl_reg[`CPRX_BIT_NO_DECRYPT] ?
				encrypted_pixel : decrypted_pixel;
		end
	end
	assign video_out = video_out_reg;
	assign video_valid_out = video_valid_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reenable_reg <= 1'b0;
		end else begin
			reenable_reg <= auth_start &&
				!(ctrl_reg[`CPRX_BIT_EN_MODE] && downstream_enabled);
		end
	end
	assign downstream_enable_req = reenable_reg;

	sequence ctrl_write_s;
		addr_phase && hwrite && addr_idx == `CPRX_IDX_CTRL ##1 1'b1;
	endsequence

	sequence mirror_write_s;
		addr_phase && hwrite && addr_idx == `CPRX_IDX_MIRROR ##1
			!remote_debug_load;
	endsequence

	ctrl_write_a: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_write_s |=> ctrl_reg == ($past(hwdata[7:0]) & `CPRX_CTRL_MASK))
		else $error("control register not written with masked data");

	mirror_ro_a: assert property (@(posedge clk) disable iff (!nrst)
		mirror_write_s |=> $stable(mirror_reg))
		else $error("local write changed mirror register");

	txkey_read_a: assert property (@(posedge clk) disable iff (!nrst)
		addr_phase && !hwrite && addr_idx == `CPRX_IDX_TXKV4
		|=> hrdata == {24'h00_0000, $past(tx_key_reg[39:32])})
		else $error("transmitter key byte 4 misread");

	rxkey_read_a: assert property (@(posedge clk) disable iff (!nrst)
		addr_phase && !hwrite && addr_idx == `CPRX_IDX_RXKV3
		|=> hrdata == {24'h00_0000, $past(rx_key_reg[31:24])})
		else $error("receiver key byte 3 misread");

	rxkey_low_a: assert property (@(posedge clk) disable iff (!nrst)
		addr_phase && !hwrite && addr_idx == `CPRX_IDX_RXKV0
		|=> hrdata == {24'h00_0000, $past(rx_key_reg[7:0])})
		else $error("receiver key byte 0 misread");

	upper_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		hrdata[31:8] == 24'h00_0000)
		else $error("reserved read bits not zero");

	bus_free_a: assert property (@(posedge clk) disable iff (!nrst)
		bus_activity |=> !bus_free ##1 !bus_free)
		else $error("bus free too soon after activity");

	bus_timeout_a: assert property (@(posedge clk) disable iff (!nrst)
		bus_free |-> $past(idle_reg) >= 26'(BUS_TIMEOUT_CYCLES) &&
			!$past(bus_timeout_disable))
		else $error("bus free before timeout");

	scl_sel_a: assert property (@(posedge clk) disable iff (!nrst)
		scl_half_cycles == (protect_master_fast_timing ? 8'h19 : 8'h64))
		else $error("bus timing not per fast flag");

	checksum_a: assert property (@(posedge clk) disable iff (!nrst)
		line_end && line_checksum_enable |=> line_checksum_valid &&
			line_checksum == ~$past(chk_acc_reg))
		else $error("line checksum missing or wrong");

	bypass_a: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_reg[`CPRX_BIT_NO_DECRYPT] |=> video_out == $past(encrypted_pixel))
		else $error("bypass did not pass encrypted data");

	reenable_a: assert property (@(posedge clk) disable iff (!nrst)
		auth_start && !ctrl_reg[`CPRX_BIT_EN_MODE] |=> downstream_enable_req)
		else $error("re-enable missing at authentication start");

	speedup_a: assert property (@(posedge clk) disable iff (!nrst)
		remote_debug_load |=> auth_timer_speedup ==
			$past(remote_debug_value[`CPRX_BIT_SPEEDUP]))
		else $error("speed-up flag not mirrored");
endmodule : cprx_debug_regs

/* design/cprx_interval.sv */
// frame interval counter giving one pulse every period ticks
`timescale 1ns/1ns
`include "cprx_defines.svh"
module cprx_interval (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic restart,
	input wire cprx_pkg::cprx_byte_t period,
	output logic hit
);
	import cprx_pkg::*;
	cprx_byte_t cnt_reg;
	logic hit_reg;
	logic last;

	assign last = (cnt_reg == (period - 8'h01));
	assign hit = hit_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= 8'h00;
		end else if (restart) begin
			cnt_reg <= 8'h00;
		end else if (tick) begin
			cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hit_reg <= 1'b0;
		end else begin
			hit_reg <= tick && last && !restart;
		end
	end

	interval_hit_a: assert property (@(posedge clk) disable iff (!nrst)
		hit |-> $past(cnt_reg) == $past(period) - 8'h01)
		else $error("interval pulse at wrong count");
endmodule : cprx_interval

/* verification/cprx_remote_tx.sv */
// remote transmitter model: pushes debug settings and its key vector
`timescale 1ns/1ns
module cprx_remote_tx (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cmd_dbg,
	input wire cprx_pkg::cprx_byte_t cmd_dbg_val,
	input wire logic cmd_key,
	input wire logic [39:0] cmd_key_val,
	output cprx_pkg::cprx_byte_t remote_debug_value,
	output logic remote_debug_load,
	output logic [39:0] tx_key_vector,
	output logic tx_key_load
);
	import cprx_pkg::*;
	// idle lines toggle so a stale value never looks valid
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			remote_debug_load <= 1'h0;
			remote_debug_value <= 8'h00;
		end else begin
			remote_debug_load <= cmd_dbg;
			remote_debug_value <= cmd_dbg ? cmd_dbg_val : ~remote_debug_value;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_key_load <= 1'h0;
			tx_key_vector <= 40'h0;
		end else begin
			tx_key_load <= cmd_key;
			tx_key_vector <= cmd_key ? cmd_key_val : ~tx_key_vector;
		end
	end
endmodule : cprx_remote_tx

/* verification/testbench.sv */
// self-checking bench for the protection receiver register bank
`timescale 1ns/1ns
`include "cprx_defines.svh"
`define CHK(a, b) begin \
	cmp_count++; \
	if ((a) !== (b)) begin \
		failures++; \
		$display("Error t=%0t got %h exp %h", $time, a, b); \
	end \
end
module testbench;
	import cprx_pkg::*;
	localparam int TMO = 20;
	localparam logic [9:0] IDX [14] = '{`CPRX_IDX_RXKV0, `CPRX_IDX_RXKV1,
		`CPRX_IDX_RXKV2, `CPRX_IDX_RXKV3, `CPRX_IDX_RXKV4, `CPRX_IDX_TXKV0,
		`CPRX_IDX_TXKV1, `CPRX_IDX_TXKV2, `CPRX_IDX_TXKV3, `CPRX_IDX_TXKV4,
		`CPRX_IDX_MIRROR, `CPRX_IDX_CTRL, 10'h085, 10'h0C2};
	logic clk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, bus_free, bus_timeout_disable, auth_timer_speedup;
	logic protect_master_fast_timing, fast_link_verify, short_check_strobe;
	logic long_check_strobe, line_checksum_enable, line_checksum_valid;
	logic video_valid_out, downstream_enable_req, remote_debug_load;
	logic tx_key_load, rx_key_load = 1'h0, cmd_dbg = 1'h0, cmd_key = 1'h0;
	logic bus_activity = 1'h0, frame_start = 1'h0, pix_valid = 1'h0;
	logic line_end = 1'h0, video_valid_in = 1'h0, auth_start = 1'h0;
	logic downstream_enabled = 1'h0;
	logic [39:0] rx_key_vector = 40'h0, tx_key_vector, cmd_key_val = 40'h0;
	logic [39:0] rxk = 40'h0, txk = 40'h0;
	cprx_byte_t remote_debug_value, scl_half_cycles, cmd_dbg_val = 8'h00;
	cprx_byte_t mir = 8'h00, ctl = 8'h00;
	cprx_pixel_t pix_in = 24'h0, decrypted_pixel = 24'h0, video_out;
	cprx_pixel_t encrypted_pixel = 24'h0, line_checksum;
	int failures = 0;
	int cmp_count = 0;

	cprx_debug_regs #(.BUS_TIMEOUT_CYCLES(TMO)) i_cprx_debug_regs (
		.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rx_key_vector(rx_key_vector),
		.rx_key_load(rx_key_load), .tx_key_vector(tx_key_vector),
		.tx_key_load(tx_key_load), .remote_debug_value(remote_debug_value),
		.remote_debug_load(remote_debug_load), .bus_activity(bus_activity),
		.bus_free(bus_free), .bus_timeout_disable(bus_timeout_disable),
		.protect_master_fast_timing(protect_master_fast_timing),
		.scl_half_cycles(scl_half_cycles),
		.auth_timer_speedup(auth_timer_speedup), .frame_start(frame_start),
		.fast_link_verify(fast_link_verify),
		.short_check_strobe(short_check_strobe),
		.long_check_strobe(long_check_strobe), .pix_valid(pix_valid),
		.pix_in(pix_in), .line_end(line_end),
		.line_checksum_enable(line_checksum_enable),
		.line_checksum(line_checksum),
		.line_checksum_valid(line_checksum_valid),
		.decrypted_pixel(decrypted_pixel), .encrypted_pixel(encrypted_pixel),
		.video_valid_in(video_valid_in), .video_out(video_out),
		.video_valid_out(video_valid_out), .auth_start(auth_start),
		.downstream_enabled(downstream_enabled),
		.downstream_enable_req(downstream_enable_req)
	);
	cprx_remote_tx i_cprx_remote_tx (
		.clk(clk), .nrst(nrst), .cmd_dbg(cmd_dbg), .cmd_dbg_val(cmd_dbg_val),
		.cmd_key(cmd_key), .cmd_key_val(cmd_key_val),
		.remote_debug_value(remote_debug_value),
		.remote_debug_load(remote_debug_load),
		.tx_key_vector(tx_key_vector), .tx_key_load(tx_key_load)
	);

	always #25 clk = ~clk;

	task automatic complete_run;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// address phase, then data phase; each held until hready is seen
	task automatic bus(input logic w, input logic [9:0] i,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		hsel <= 1'h1;
		htrans <= `CPRX_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {20'h0, i, 2'h0};
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (hreadyout !== 1'h1 && n < 20);
			if (hreadyout !== 1'h1) begin
				failures++;
				complete_run();
			end
			if (p == 0) begin
				htrans <= 2'h0;
				hwdata <= d;
			end
		end
		r = hrdata;
	endtask : bus

	function automatic logic [31:0] exp_reg(input logic [9:0] i);
		logic [31:0] r;
		r = 32'h0;
		if (i >= `CPRX_IDX_RXKV0 && i <= `CPRX_IDX_RXKV4)
			r[7:0] = rxk[8*(i-`CPRX_IDX_RXKV0)+:8];
		if (i >= `CPRX_IDX_TXKV0 && i <= `CPRX_IDX_TXKV4)
			r[7:0] = txk[8*(i-`CPRX_IDX_TXKV0)+:8];
		if (i == `CPRX_IDX_MIRROR)
			r[7:0] = mir;
		if (i == `CPRX_IDX_CTRL)
			r[7:0] = ctl;
		return r;
	endfunction : exp_reg

	// per channel end-around-carry sum, sent inverted
	function automatic cprx_pixel_t exp_sum(input cprx_pixel_t q[$]);
		cprx_pixel_t r;
		int s;
		for (int c = 0; c < 3; c++) begin
			s = 0;
			foreach (q[i]) begin
				s = s + q[i][8*c+:8];
				s = (s & 32'hFF) + (s >> 8);
			end
			r[8*c+:8] = ~s[7:0];
		end
		return r;
	endfunction : exp_sum

	task automatic check_all;
		logic [31:0] r;
		foreach (IDX[k]) begin
			bus(1'h0, IDX[k], 32'h0, r);
			`CHK(r, exp_reg(IDX[k]))
			`CHK(hresp, 1'h0)
		end
	endtask : check_all

	task automatic send_dbg(input cprx_byte_t v);
		cmd_dbg <= 1'h1;
		cmd_dbg_val <= v;
		@(posedge clk);
		cmd_dbg <= 1'h0;
		repeat (3) @(posedge clk);
		mir = v & `CPRX_MIRROR_MASK;
	endtask : send_dbg

	initial begin
		logic [31:0] r;
		logic [31:0] rnd;
		cprx_pixel_t q[$];
		cprx_pixel_t px;
		int n, s, l;
		void'($urandom(43472));
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		@(posedge clk);
		check_all();
		$display("test reset done");
		repeat (4) begin
			rxk = {8'($urandom()), $urandom()};
			txk = {8'($urandom()), $urandom()};
			rx_key_vector <= rxk;
			rx_key_load <= 1'h1;
			cmd_key_val <= txk;
			cmd_key <= 1'h1;
			@(posedge clk);
			rx_key_load <= 1'h0;
			cmd_key <= 1'h0;
			send_dbg(8'($urandom()));
			// writes everywhere: only control may change
			foreach (IDX[k]) begin
				rnd = $urandom();
				bus(1'h1, IDX[k], rnd, r);
				if (IDX[k] == `CPRX_IDX_CTRL)
					ctl = rnd[7:0] & `CPRX_CTRL_MASK;
			end
			check_all();
			`CHK(bus_timeout_disable, mir[6])
			`CHK(protect_master_fast_timing, mir[0])
			`CHK(scl_half_cycles, mir[0] ? 8'h19 : 8'h64)
			`CHK(auth_timer_speedup, mir[1])
			`CHK(fast_link_verify, mir[2])
			`CHK(line_checksum_enable, mir[3])
		end
		$display("test registers done");
		for (int m = 0; m < 8; m++) begin
			ctl = 8'(m[1:0]);
			bus(1'h1, `CPRX_IDX_CTRL, 32'(m), r);
			@(posedge clk);
			decrypted_pixel <= 24'($urandom());
			encrypted_pixel <= 24'($urandom());
			video_valid_in <= 1'h1;
			auth_start <= 1'h1;
			downstream_enabled <= m[2];
			@(posedge clk);
			video_valid_in <= 1'h0;
			auth_start <= 1'h0;
			@(posedge clk);
			`CHK(video_out, ctl[1] ? encrypted_pixel : decrypted_pixel)
			`CHK(video_valid_out, 1'h1)
			`CHK(downstream_enable_req, !(ctl[0] && m[2]))
			@(posedge clk);
			`CHK(video_valid_out, 1'h0)
			`CHK(downstream_enable_req, 1'h0)
		end
		$display("test control done");
		for (int e = 0; e < 2; e++) begin
			send_dbg(e ? 8'h08 : 8'h00);
			q = {};
			repeat (1 + $urandom() % 8) begin
				px = 24'($urandom());
				q.push_back(px);
				pix_in <= px;
				pix_valid <= 1'h1;
				@(posedge clk);
			end
			pix_valid <= 1'h0;
			line_end <= 1'h1;
			@(posedge clk);
			line_end <= 1'h0;
			@(posedge clk);
			`CHK(line_checksum_valid, 1'(e))
			if (e)
				`CHK(line_checksum, exp_sum(q))
		end
		$display("test checksum done");
		for (int f = 1; f >= 0; f--) begin
			send_dbg(f ? 8'h04 : 8'h00);
			s = 0;
			l = 0;
			for (int k = 1; k <= 128; k++) begin
				frame_start <= 1'h1;
				@(posedge clk);
				frame_start <= 1'h0;
				@(posedge clk);
				if (short_check_strobe === 1'h1 && s == 0)
					s = k;
				if (long_check_strobe === 1'h1 && l == 0)
					l = k;
			end
			`CHK(s, f ? 2 : 16)
			`CHK(l, f ? 16 : 128)
		end
		$display("test intervals done");
		for (int d = 0; d < 2; d++) begin
			send_dbg(d ? 8'h40 : 8'h00);
			bus_activity <= 1'h1;
			@(posedge clk);
			bus_activity <= 1'h0;
			@(posedge clk);
			`CHK(bus_free, 1'h0)
			n = 1;
			// idle window is short on purpose: a hang is cut at 40
			while (bus_free !== 1'h1 && n < 40) begin
				@(posedge clk);
				n++;
			end
			`CHK(n == TMO + 2, d == 0)
		end
		$display("test bus idle done");
		complete_run();
	end
endmodule : testbench
